// ===== eprom_ctrl_consts.vh
// Purpose: constants for the byte-wide EPROM read/program controller
// Assumes: 10 MHz clock, 100 ns period
// Notes: times are kept in their printed units; counts derive from them
`ifndef EPROM_CTRL_CONSTS_VH
`define EPROM_CTRL_CONSTS_VH
`define CLK_NS 100
`define ADDR_W 15
`define DATA_W 8
`define ID_PIN_BIT 9
`define ID_SEL_BIT 0
// fast pulse width 100 us nominal, window 95.0..105.0 us
`define FAST_PULSE_US 100
`define FAST_PULSE_CYC ((`FAST_PULSE_US * 1000) / `CLK_NS)
// adaptive initial pulse 1.0 ms nominal, window 0.95..1.05 ms
`define ADAPT_PULSE_US 1000
`define ADAPT_PULSE_CYC ((`ADAPT_PULSE_US * 1000) / `CLK_NS)
// overprogram pulse per retry step: 3 ms (window 2.85..78.5 ms)
`define OVER_STEP_US 3000
`define OVER_STEP_CYC ((`OVER_STEP_US * 1000) / `CLK_NS)
// setup/hold around strobes: 2.0 us least, rounded up
`define SETUP_NS 2000
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
// read access wait: 150 ns data valid, rounded up
`define ACCESS_NS 150
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define RETRY_MAX 25
`define ALGO_FAST 1'b0
`define ALGO_ADAPT 1'b1
`endif

// ===== eprom_host_ctrl.v
// Purpose: host/programmer that reads, identifies and programs a 32K x 8 EPROM
// Assumes: device pins driven directly; program_supply_hi switches the external supply
// Notes: one command at a time; a command may be taken while cmd_ready is high, busy falls one cycle after cmd_ready rises
// Summary of operation
// - raised supply, select low, drive high: host drives data, zeros get written.
// - raised supply, select high, drive low: device shows the byte for verify.
// - both low, id voltage on pin 9, other addresses low: maker code out.
// - same with id_code_select high: part-type code out.
// - fast algorithm program pulse lasts 95.0 to 105.0 us.
// - adaptive algorithm initial pulse lasts 0.95 to 1.05 ms.
// - adaptive algorithm overprogram pulse lasts 2.85 to 78.5 ms.
// - verify every programmed byte after its pulse.
`timescale 1ns/1ps
`include "eprom_ctrl_consts.vh"
module eprom_host_ctrl #(
    parameter FAST_CYC = `FAST_PULSE_CYC,
    parameter ADAPT_CYC = `ADAPT_PULSE_CYC,
    parameter OVER_CYC = `OVER_STEP_CYC,
    parameter RETRIES = `RETRY_MAX
)(
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [1:0] cmd_op,
    input wire algo_sel,
    input wire [`ADDR_W-1:0] cmd_addr,
    input wire [`DATA_W-1:0] cmd_wdata,
    output reg [`DATA_W-1:0] rsp_data_reg,
    output reg rsp_valid_reg,
    output reg rsp_fail_reg,
    output reg busy_reg,
    output reg [`ADDR_W-1:0] mem_addr_reg,
    output reg id_voltage_en_reg,
    output reg device_select_n_reg,
    output reg output_drive_n_reg,
    output reg program_supply_hi_reg,
    input wire [`DATA_W-1:0] data_in,
    output reg [`DATA_W-1:0] data_out_reg,
    output reg data_oe_n_reg
);
// ==================================================
// commands and states
localparam OP_READ = 2'h0;
localparam OP_ID_PART = 2'h2; // 2'h1 asks for the maker code
localparam OP_PROG = 2'h3;
localparam S_IDLE = 4'h0;
localparam S_RD_SET = 4'h1;
localparam S_RD_WAIT = 4'h2;
localparam S_PG_SET = 4'h3;
localparam S_PG_PULSE = 4'h4;
localparam S_PG_HOLD = 4'h5;
localparam S_VF_WAIT = 4'h6;
localparam S_VF_CHECK = 4'h7;
localparam S_OV_PULSE = 4'h8;
localparam S_DONE = 4'h9;
localparam S_PG_EXIT = 4'hA;
// ==================================================
// reset synchroniser
reg rst_s1_reg;
reg rst_s2_reg;
wire srst_n = rst_s2_reg;
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end
    else
    begin
        rst_s1_reg <= 1'b1;
        rst_s2_reg <= rst_s1_reg;
    end
end
// ==================================================
// data pin input: three flops, accept when the last two agree
reg [`DATA_W-1:0] din_s1_reg;
reg [`DATA_W-1:0] din_s2_reg;
reg [`DATA_W-1:0] din_s3_reg;
reg [`DATA_W-1:0] din_ok_reg;
always @(posedge clk or negedge srst_n)
begin
    if (!srst_n)
    begin
        din_s1_reg <= 8'hFF;
        din_s2_reg <= 8'hFF;
        din_s3_reg <= 8'hFF;
        din_ok_reg <= 8'hFF;
    end
    else
    begin
        din_s1_reg <= data_in;
        din_s2_reg <= din_s1_reg;
        din_s3_reg <= din_s2_reg;
        if (din_s2_reg == din_s3_reg)
            din_ok_reg <= din_s3_reg;
    end
end
// ==================================================
// sequencer
reg [3:0] state_reg;
reg [19:0] cnt_reg;
reg [7:0] tries_reg;
reg algo_reg;
reg [`DATA_W-1:0] target_reg;
wire verify_ok;
// erased bits read one, so the byte verifies only when every intended zero reads zero and every intended one reads one
assign verify_ok = ((din_ok_reg & ~target_reg) == 8'h00) && ((din_ok_reg | ~target_reg) == 8'hFF);
assign cmd_ready = (state_reg == S_IDLE);
always @(posedge clk or negedge srst_n)
begin
    if (!srst_n)
    begin
        state_reg <= S_IDLE;
        cnt_reg <= 20'h00000;
        tries_reg <= 8'h00;
        algo_reg <= `ALGO_FAST;
        target_reg <= 8'hFF;
        rsp_data_reg <= 8'h00;
        rsp_valid_reg <= 1'b0;
        rsp_fail_reg <= 1'b0;
        busy_reg <= 1'b0;
        mem_addr_reg <= 15'h0000;
        id_voltage_en_reg <= 1'b0;
        device_select_n_reg <= 1'b1;
        output_drive_n_reg <= 1'b1;
        program_supply_hi_reg <= 1'b0;
        data_out_reg <= 8'hFF;
        data_oe_n_reg <= 1'b1;
    end
    else
    begin
        rsp_valid_reg <= 1'b0;
        case (state_reg)
        S_IDLE:
        begin
            busy_reg <= 1'b0; // pins already released by reset, the exit state or the done state
            if (cmd_valid)
            begin
                busy_reg <= 1'b1;
                algo_reg <= algo_sel;
                target_reg <= cmd_wdata;
                tries_reg <= 8'h00;
                cnt_reg <= 20'h00000;
                if (cmd_op == OP_PROG)
                begin
                    mem_addr_reg <= cmd_addr;
                    data_out_reg <= cmd_wdata;
                    program_supply_hi_reg <= 1'b1;
                    state_reg <= S_PG_SET;
                end
                else if (cmd_op == OP_READ)
                begin
                    mem_addr_reg <= cmd_addr;
                    state_reg <= S_RD_SET;
                end
                else
                begin
                    // identification: all addresses low except the code select
                    mem_addr_reg <= {14'h0000, (cmd_op == OP_ID_PART)};
                    id_voltage_en_reg <= 1'b1;
                    state_reg <= S_RD_SET;
                end
            end
        end
        S_RD_SET:
        begin
            // address and supply settle before selecting
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= `SETUP_CYC - 1)
            begin
                device_select_n_reg <= 1'b0;
                output_drive_n_reg <= 1'b0;
                cnt_reg <= 20'h00000;
                state_reg <= S_RD_WAIT;
            end
        end
        S_RD_WAIT:
        begin
            // wait access time plus the input synchroniser
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= `ACCESS_CYC + 4)
            begin
                rsp_data_reg <= din_ok_reg;
                state_reg <= S_DONE;
            end
        end
        S_PG_SET:
        begin
            // supply raised, both controls high: inhibit while data sets up
            data_oe_n_reg <= 1'b0;
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= `SETUP_CYC - 1)
            begin
                cnt_reg <= 20'h00000;
                device_select_n_reg <= 1'b0;
                state_reg <= S_PG_PULSE;
            end
        end
        S_PG_PULSE:
        begin
            cnt_reg <= cnt_reg + 20'h00001;
            if ((algo_reg == `ALGO_FAST && cnt_reg >= FAST_CYC - 1) ||
                (algo_reg == `ALGO_ADAPT && cnt_reg >= ADAPT_CYC - 1))
            begin
                device_select_n_reg <= 1'b1;
                cnt_reg <= 20'h00000;
                tries_reg <= tries_reg + 8'h01;
                state_reg <= S_PG_HOLD;
            end
        end
        S_PG_HOLD:
        begin
            // data hold, then release pins and enter verify
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= `SETUP_CYC - 1)
            begin
                data_oe_n_reg <= 1'b1;
                output_drive_n_reg <= 1'b0;
                cnt_reg <= 20'h00000;
                state_reg <= S_VF_WAIT;
            end
        end
        S_VF_WAIT:
        begin
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= `ACCESS_CYC + 4)
                state_reg <= S_VF_CHECK;
        end
        S_VF_CHECK:
        begin
            output_drive_n_reg <= 1'b1;
            rsp_data_reg <= din_ok_reg;
            cnt_reg <= 20'h00000;
            if (verify_ok && algo_reg == `ALGO_ADAPT)
            begin
                // overprogram scaled by pulses used
                data_oe_n_reg <= 1'b0;
                device_select_n_reg <= 1'b0;
                state_reg <= S_OV_PULSE;
            end
            else if (verify_ok)
                state_reg <= S_PG_EXIT;
            else if (tries_reg >= RETRIES)
            begin
                rsp_fail_reg <= 1'b1;
                state_reg <= S_PG_EXIT;
            end
            else
            begin
                data_oe_n_reg <= 1'b0;
                state_reg <= S_PG_SET;
            end
        end
        S_OV_PULSE:
        begin
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg >= OVER_CYC - 1)
            begin
                cnt_reg <= 20'h00000;
                if (tries_reg <= 8'h01)
                begin
                    device_select_n_reg <= 1'b1;
                    state_reg <= S_PG_EXIT;
                end
                else
                    tries_reg <= tries_reg - 8'h01;
            end
        end
        S_PG_EXIT:
        begin
            data_oe_n_reg <= 1'b1; // select is already high: inhibit before the supply drops
            program_supply_hi_reg <= 1'b0;
            state_reg <= S_DONE;
        end
        S_DONE:
        begin
            device_select_n_reg <= 1'b1;
            output_drive_n_reg <= 1'b1;
            id_voltage_en_reg <= 1'b0;
            rsp_valid_reg <= 1'b1;
            state_reg <= S_IDLE;
        end
        default:
            state_reg <= S_IDLE;
        endcase
        if (state_reg == S_IDLE && cmd_valid)
            rsp_fail_reg <= 1'b0;
    end
end
endmodule // eprom_host_ctrl

// ===== eprom_host_ctrl_assertions.sv
// Purpose: pin checks on the eprom host controller
// Assumes: bound onto eprom_host_ctrl
// Notes: pulse lengths follow the instance parameters
`timescale 1ns/1ps
module eprom_host_ctrl_assertions #(
    parameter FAST_CYC = 10,
    parameter ADAPT_CYC = 20,
    parameter OVER_CYC = 30
)(
    input wire clk,
    input wire rst_n,
    input wire cmd_ready,
    input wire rsp_valid_reg,
    input wire [14:0] mem_addr_reg,
    input wire id_voltage_en_reg,
    input wire device_select_n_reg,
    input wire output_drive_n_reg,
    input wire program_supply_hi_reg,
    input wire data_oe_n_reg
);
// ==========
// helpers
reg [19:0] low_reg;
wire sel_n = device_select_n_reg;
wire drv_n = output_drive_n_reg;
wire vpp = program_supply_hi_reg;
wire oe_n = data_oe_n_reg;
// counts select-low cycles while supply raised
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        low_reg <= 20'h00000;
    else if (!sel_n && vpp)
        low_reg <= low_reg + 20'h00001;
    else
        low_reg <= 20'h00000;
end
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_pulse_end;
    vpp && $rose(sel_n);
endsequence
sequence s_try_end;
    s_pulse_end ##0 (low_reg == FAST_CYC || low_reg == ADAPT_CYC);
endsequence
// ==========
// assertions
chk_pulse_width: assert property (s_pulse_end |-> low_reg == FAST_CYC ||
    low_reg == ADAPT_CYC || (low_reg % OVER_CYC == 0 && low_reg != 0)) else $error("bad pulse width");
chk_verify_follows: assert property (s_try_end |-> ##[1:40] !drv_n)
    else $error("no verify after pulse");
chk_prog_pins: assert property (vpp && !sel_n |-> drv_n && !oe_n)
    else $error("program pins wrong");
chk_verify_pins: assert property (vpp && !drv_n |-> sel_n && oe_n)
    else $error("verify pins wrong");
chk_read_float: assert property (!sel_n && !drv_n |-> oe_n && !vpp)
    else $error("host drives during read");
chk_id_address: assert property (id_voltage_en_reg |-> mem_addr_reg[14:1] == 14'h0000 && !vpp)
    else $error("id address not low");
chk_idle_pins: assert property (cmd_ready |-> sel_n && drv_n && !vpp && oe_n)
    else $error("idle pins wrong");
chk_rsp_pulse: assert property (rsp_valid_reg |=> !rsp_valid_reg)
    else $error("response too long");
endmodule // eprom_host_ctrl_assertions
bind eprom_host_ctrl eprom_host_ctrl_assertions #(.FAST_CYC(FAST_CYC), .ADAPT_CYC(ADAPT_CYC),
    .OVER_CYC(OVER_CYC)) chk_inst (.clk(clk), .rst_n(rst_n), .cmd_ready(cmd_ready),
    .rsp_valid_reg(rsp_valid_reg), .mem_addr_reg(mem_addr_reg), .id_voltage_en_reg(id_voltage_en_reg),
    .device_select_n_reg(device_select_n_reg), .output_drive_n_reg(output_drive_n_reg),
    .program_supply_hi_reg(program_supply_hi_reg), .data_oe_n_reg(data_oe_n_reg));

// ===== eprom_dev_model.sv
// Purpose: behavioural byte-wide eprom at its pins
// Assumes: pins come straight from the controller
// Notes: id codes are arbitrary values
`timescale 1ns/1ps
module eprom_dev_model #(
    parameter MAKER_ID = 8'h5A, // arbitrary value
    parameter PART_ID = 8'hC3 // arbitrary value
)(
    input wire clk,
    input wire [14:0] addr,
    input wire id_hv,
    input wire sel_n,
    input wire drv_n,
    input wire vpp,
    input wire [7:0] host_d,
    input wire host_oe_n,
    output wire [7:0] pins
);
// ==========
// storage, erased to ones
reg [7:0] mem [0:32767];
reg [7:0] last_reg;
integer i;
initial
begin
    for (i = 0; i < 32768; i = i + 1)
        mem[i] = 8'hFF;
    last_reg = 8'h00;
end
// a pulse clears only the zero bits
always @(negedge sel_n)
begin
    if (vpp && drv_n)
        mem[addr] = mem[addr] & pins;
end
// read, verify and signature decode
wire id_on = id_hv && addr[14:1] == 14'h0000 && !vpp;
wire rd_on = !sel_n && !drv_n && !vpp;
wire vf_on = sel_n && !drv_n && vpp;
wire [7:0] dev_q = id_on ? (addr[0] ? PART_ID : MAKER_ID) : mem[addr];
assign pins = !host_oe_n ? host_d : (rd_on || vf_on) ? dev_q : ~last_reg;
// floating pins show the inverse of the last level
always @(posedge clk)
    last_reg <= pins;
endmodule // eprom_dev_model

// ===== eprom_host_ctrl_tb_top.sv
// Purpose: scenario bench for the eprom host controller
// Assumes: short pulse counts
// Notes: expected codes match the model parameters
`timescale 1ns/1ps
module eprom_host_ctrl_tb_top;
reg clk = 1'b0;
reg rst_n; // left unknown so the first assignment makes a falling edge
reg vld = 1'b0;
reg [1:0] op = 2'h0;
reg alg = 1'b0;
reg [14:0] adr = 15'h0000;
reg [7:0] wd = 8'h00;
wire rdy, rv, rf, bsy, idv, sel_n, drv_n, vpp, oe_n;
wire [7:0] rd, pins, dout;
wire [14:0] ma;
integer bad_count = 0;
integer checks_done = 0;
integer cyc = 0;
integer plen = 0;
integer last_len = 0;
integer prev_len = 0;
always #50 clk = ~clk;
// ==========
// design and device
eprom_host_ctrl #(.FAST_CYC(10), .ADAPT_CYC(20), .OVER_CYC(30), .RETRIES(3)) eprom_host_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .cmd_valid(vld), .cmd_ready(rdy), .cmd_op(op), .algo_sel(alg),
    .cmd_addr(adr), .cmd_wdata(wd), .rsp_data_reg(rd), .rsp_valid_reg(rv), .rsp_fail_reg(rf),
    .busy_reg(bsy), .mem_addr_reg(ma), .id_voltage_en_reg(idv), .device_select_n_reg(sel_n),
    .output_drive_n_reg(drv_n), .program_supply_hi_reg(vpp), .data_in(pins),
    .data_out_reg(dout), .data_oe_n_reg(oe_n));
eprom_dev_model eprom_dev_model_inst (.clk(clk), .addr(ma), .id_hv(idv), .sel_n(sel_n),
    .drv_n(drv_n), .vpp(vpp), .host_d(dout), .host_oe_n(oe_n), .pins(pins));
// ==========
// helpers
// length of each program pulse, select low with supply raised
always @(posedge clk)
begin
    if (!sel_n && vpp)
        plen <= plen + 1;
    else if (plen != 0)
    begin
        prev_len <= last_len;
        last_len <= plen;
        plen <= 0;
    end
end
task check(input [63:0] nm, input [7:0] e, input [7:0] g);
begin
    checks_done = checks_done + 1;
    if (e !== g)
    begin
        bad_count = bad_count + 1;
        $display("FAIL %0s exp %h got %h", nm, e, g);
    end
end
endtask
// one command, waits for its response
task cmd(input [1:0] o, input a, input [14:0] ad, input [7:0] d);
integer n;
begin
    n = 0;
    @(negedge clk);
    check("idle", 8'h00, {7'h00, bsy});
    op = o;
    alg = a;
    adr = ad;
    wd = d;
    vld = 1'b1;
    while (rdy !== 1'b1 && n < 500)
    begin
        n = n + 1;
        @(negedge clk);
    end
    @(negedge clk);
    vld = 1'b0;
    check("busy", 8'h01, {7'h00, bsy});
    while (rv !== 1'b1 && n < 3000)
    begin
        n = n + 1;
        @(negedge clk);
    end
    check("resp", 8'h01, {7'h00, rv});
end
endtask
task print_verdict;
begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
// ==========
// scenarios
task t_read_ids;
begin
    cmd(2'h0, 1'b0, 15'h7FFF, 8'h00);
    check("erased", 8'hFF, rd);
    cmd(2'h1, 1'b0, 15'h7FFF, 8'h00);
    check("maker", 8'h5A, rd);
    cmd(2'h2, 1'b0, 15'h0000, 8'h00);
    check("part", 8'hC3, rd);
end
endtask
task t_program;
begin
    cmd(2'h3, 1'b0, 15'h1234, 8'hA5);
    check("fastfail", 8'h00, {7'h00, rf});
    check("fastlen", 8'h0A, last_len[7:0]);
    cmd(2'h0, 1'b0, 15'h1234, 8'h00);
    check("fastrd", 8'hA5, rd);
    cmd(2'h3, 1'b1, 15'h4001, 8'h3C);
    check("adptfail", 8'h00, {7'h00, rf});
    check("adptlen", 8'h14, prev_len[7:0]);
    check("overlen", 8'h1E, last_len[7:0]);
    cmd(2'h0, 1'b0, 15'h4001, 8'h00);
    check("adptrd", 8'h3C, rd);
end
endtask
// ones cannot be restored, so verify keeps failing
task t_reprogram;
begin
    cmd(2'h3, 1'b0, 15'h1234, 8'h5A);
    check("retry", 8'h01, {7'h00, rf});
    check("vfdata", 8'h00, rd);
    cmd(2'h0, 1'b0, 15'h1234, 8'h00);
    check("cleared", 8'h00, {7'h00, rf});
    check("anded", 8'h00, rd);
end
endtask
// ==========
// watchdog and main sequence
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        bad_count = bad_count + 1;
        print_verdict;
    end
end
initial
begin
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_read_ids;
    t_program;
    t_reprogram;
    print_verdict;
end
endmodule // eprom_host_ctrl_tb_top
